// >>> logic/ise_pkg.sv
// shared constants and carrier types of the infrared serial endec
package ise_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register indices, byte address is four times the index
  localparam logic [7:0] CTRL_INDEX = 8'hbf;
  localparam logic [7:0] STAT_INDEX = 8'hc0;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {2'h0, STAT_INDEX, 2'h0};

  // control field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_RXEN_BIT   = 1;
  localparam int CTRL_LOOP_BIT   = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // status field positions
  localparam int STAT_TXBUSY_BIT = 0;
  localparam int STAT_RXBUSY_BIT = 1;
  localparam int STAT_RXD_BIT    = 2;
  localparam int STAT_PULSE_BIT  = 3;

  // bit cell in baud clock ticks and the zero-bit pulse window
  localparam int BIT_TICKS   = 16;
  localparam int PULSE_FIRST = 7;
  localparam int PULSE_TICKS = 3;
  localparam logic [3:0] CNT_LAST    = 4'hf;
  localparam logic [3:0] PULSE_START = 4'h7;
  localparam logic [3:0] PULSE_END   = 4'h9;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } ise_axi_req_type;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } ise_axi_rsp_type;

  typedef struct packed {
    logic loopback;
    logic receiveEnable;
    logic endecEnable;
  } ise_ctrl_type;

endpackage

// >>> logic/ise_pulse_decoder.sv
// receive decoder: infrared pulses back to uart levels
module ise_pulse_decoder (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic rxOn,
  input  wire logic baudTick,
  input  wire logic pulseIn,
  output logic      uartRxd,
  output logic      rxBusy
);

  logic       lastLevel;
  logic [3:0] cellCnt;
  logic       pulseSeen;
  logic       cellDone;

  // a falling input level seen on a baud tick marks a zero bit
  assign pulseSeen = rxOn & baudTick & lastLevel & ~pulseIn;  // R06
  assign cellDone  = baudTick & rxBusy & (cellCnt == ise_pkg::CNT_LAST);

  // each pulse restarts a 16 tick low cell, a silent cell returns high
  always_ff @(posedge core_clk) begin
    if (!rst_b || !rxOn) begin
      lastLevel <= 1'b1;
      cellCnt   <= 4'h0;
      rxBusy    <= 1'b0;
      uartRxd   <= 1'b1;  // R18
    end else begin
      if (baudTick) begin
        lastLevel <= pulseIn;
      end
      if (pulseSeen) begin
        cellCnt <= 4'h0;
        rxBusy  <= 1'b1;
        uartRxd <= 1'b0;  // R05
      end else if (cellDone) begin
        rxBusy  <= 1'b0;
        uartRxd <= 1'b1;  // R04
      end else if (baudTick && rxBusy) begin
        cellCnt <= cellCnt + 4'h1;  // R07
      end
    end
  end

  // a pulse on a tick drives the uart line low on the next clock
  a_rx_zero_start : assert property (@(posedge core_clk) disable iff (!rst_b)
    pulseSeen |=> !uartRxd && cellCnt == 4'h0)  // R05
    else $error("decoder missed a received pulse");

  // a low cell ends exactly sixteen ticks after its pulse
  a_rx_cell_end : assert property (@(posedge core_clk) disable iff (!rst_b)
    rxOn && cellDone && !pulseSeen |=> uartRxd && !rxBusy)  // R07
    else $error("decoded zero cell has wrong length");

endmodule

// >>> logic/ise_endec.sv
// infrared serial endec top: register slave, encoder, loopback and decoder
//
// Behaviour
// R01 - encoder times each uart bit as sixteen baud clock ticks
// R02 - a one bit keeps the infrared output low all sixteen ticks
// R03 - a zero bit gives seven low, three high, then six low ticks
// R04 - sixteen high input ticks decode to a uart one
// R05 - seven high, three low, six high input ticks decode to a zero
// R06 - decoded receive signal is timed by the baud clock
// R07 - first decoded bit may jitter, later bits are sixteen ticks wide
// R08 - decoded data reaches the uart only while receive enable is set
// R09 - when enabled, transmit is encoded and receive decoded
// R10 - software keeps the link half duplex, no transmit while receiving
// R11 - software clears receive enable during transmission
// R12 - uart and baud generator are set up before endec use
// R13 - the two infrared port lines use alternate function mode seven
// R14 - software disables the modem status interrupt while endec is used
// R15 - loopback inverts the output and feeds it to the receive input
// R16 - receive enable low ignores input, high drives the uart receive line
// R17 - endec enable switches the whole block, resets to zero
// R18 - idle or disabled receive path holds the uart line high
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
module ise_endec (
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire ise_pkg::ise_axi_req_type axiReq,
  output ise_pkg::ise_axi_rsp_type     axiRsp,
  input  wire logic                    baudTick,
  input  wire logic                    uartTxd,
  output logic                         uartRxd,
  output logic                         irPulseOut,
  input  wire logic                    irPulseIn
);

  ise_pkg::ise_ctrl_type ctrl;

  logic                      awHave;
  logic                      wHave;
  logic [ise_pkg::ADDR_W-1:0] awAddr;
  logic [ise_pkg::DATA_W-1:0] wData;
  logic [3:0]                wStrb;
  logic                      awTake;
  logic                      wTake;
  logic                      arTake;
  logic                      doWrite;
  logic                      next_awHave;
  logic                      next_wHave;
  logic                      next_bvalid;
  logic                      next_rvalid;
  logic                      wrCtrl;
  logic                      wrStat;
  logic                      rdCtrl;
  logic                      rdStat;
  logic [ise_pkg::DATA_W-1:0] rdData;
  logic                      encActive;
  logic                      encBit;
  logic [3:0]                encCnt;
  logic [3:0]                next_encCnt;
  logic                      encStart;
  logic                      encWrap;
  logic                      next_pulse;
  logic                      rxOn;
  logic                      rxSrc;
  logic                      rxBusy;
  logic                      decRxd;

  // channel handshakes and the write that fires once both halves are held
  assign awTake  = axiReq.awvalid & axiRsp.awready;
  assign wTake   = axiReq.wvalid & axiRsp.wready;
  assign arTake  = axiReq.arvalid & axiRsp.arready;
  assign doWrite = awHave & wHave & ~axiRsp.bvalid;

  // next states of the write and read trackers
  assign next_awHave = doWrite ? 1'b0 : (awHave | awTake);
  assign next_wHave  = doWrite ? 1'b0 : (wHave | wTake);
  assign next_bvalid = doWrite |
                       (axiRsp.bvalid & ~axiReq.bready);
  assign next_rvalid = arTake |
                       (axiRsp.rvalid & ~axiReq.rready);

  // address decode for both directions
  assign wrCtrl = (awAddr == ise_pkg::CTRL_ADDR);
  assign wrStat = (awAddr == ise_pkg::STAT_ADDR);
  assign rdCtrl = (axiReq.araddr == ise_pkg::CTRL_ADDR);
  assign rdStat = (axiReq.araddr == ise_pkg::STAT_ADDR);

  // read data selection, reserved bits read as zero
  assign rdData = rdCtrl ? {29'h0, ctrl} :
                  rdStat ? {28'h0, irPulseOut, uartRxd, rxBusy, encActive} :
                  32'h0;

  // write side capture
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      awHave <= 1'b0;
      wHave  <= 1'b0;
      awAddr <= '0;
      wData  <= '0;
      wStrb  <= 4'h0;
    end else begin
      awHave <= next_awHave;
      wHave  <= next_wHave;
      if (awTake) begin
        awAddr <= axiReq.awaddr;
      end
      if (wTake) begin
        wData <= axiReq.wdata;
        wStrb <= axiReq.wstrb;
      end
    end
  end

  // control register, only the low byte lane carries fields
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ctrl <= ise_pkg::CTRL_RESET;  // R17
    end else if (doWrite && wrCtrl && wStrb[0]) begin
      ctrl <= wData[2:0];
    end
  end

  // response channels, unmapped addresses answer with a slave error
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      axiRsp <= '0;
    end else begin
      axiRsp.awready <= ~next_awHave;
      axiRsp.wready  <= ~next_wHave;
      axiRsp.bvalid  <= next_bvalid;
      axiRsp.arready <= ~next_rvalid;
      axiRsp.rvalid  <= next_rvalid;
      if (doWrite) begin
        axiRsp.bresp <= (wrCtrl | wrStat) ? ise_pkg::RESP_OKAY
                                          : ise_pkg::RESP_SLVERR;
      end
      if (arTake) begin
        axiRsp.rdata <= rdData;
        axiRsp.rresp <= (rdCtrl | rdStat) ? ise_pkg::RESP_OKAY
                                          : ise_pkg::RESP_SLVERR;
      end
    end
  end

  // encoder cell timing: a falling uart line starts a run of bit cells
  assign encStart    = ctrl.endecEnable & ~encActive & ~uartTxd;  // R09
  assign encWrap     = encActive & baudTick & (encCnt == ise_pkg::CNT_LAST);
  assign next_encCnt = encCnt + 4'h1;  // R01
  assign next_pulse  = encActive & ~encBit &
                       (next_encCnt >= ise_pkg::PULSE_START) &
                       (next_encCnt <= ise_pkg::PULSE_END);  // R03

  // encoder: bit latched at each cell start, pulse placed within the cell
  always_ff @(posedge core_clk) begin
    if (!rst_b || !ctrl.endecEnable) begin
      encActive  <= 1'b0;
      encBit     <= 1'b1;
      encCnt     <= 4'h0;
      irPulseOut <= 1'b0;  // R17
    end else if (encStart) begin
      encActive <= 1'b1;
      encBit    <= 1'b0;
      encCnt    <= 4'h0;
    end else if (encWrap) begin
      encActive  <= ~uartTxd | ~encBit;
      encBit     <= uartTxd;
      encCnt     <= 4'h0;
      irPulseOut <= 1'b0;  // R02
    end else if (encActive && baudTick) begin
      encCnt     <= next_encCnt;
      irPulseOut <= next_pulse;  // R03
    end
  end

  // receive source: loopback feeds back the inverted output
  assign rxOn  = ctrl.endecEnable & ctrl.receiveEnable;  // R08
  assign rxSrc = ctrl.loopback ? ~irPulseOut : irPulseIn;  // R15

  ise_pulse_decoder u_decoder (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .rxOn     (rxOn),
    .baudTick (baudTick),
    .pulseIn  (rxSrc),
    .uartRxd  (decRxd),
    .rxBusy   (rxBusy)
  );

  // uart receive line follows the decoder only while receiving
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      uartRxd <= 1'b1;
    end else begin
      uartRxd <= rxOn ? decRxd : 1'b1;  // R16
    end
  end

  // helper counters for the pulse and decoded cell lengths
  logic [3:0] pulseTicks;
  logic [7:0] rxLowTicks;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pulseTicks <= 4'h0;
      rxLowTicks <= 8'h0;
    end else begin
      pulseTicks <= !irPulseOut ? 4'h0 : pulseTicks + {3'h0, baudTick};
      rxLowTicks <= uartRxd ? 8'h0 : rxLowTicks + {7'h0, baudTick};
    end
  end

  a_pulse_width_three : assert property (@(posedge core_clk)  // R03
    disable iff (!rst_b) $fell(irPulseOut) && ctrl.endecEnable |->
    pulseTicks == 4'(ise_pkg::PULSE_TICKS))
    else $error("encoded pulse is not three ticks");

  a_pulse_after_seven : assert property (@(posedge core_clk)  // R03
    disable iff (!rst_b) $rose(irPulseOut) |->
    $past(next_encCnt) == 4'(ise_pkg::PULSE_FIRST) && !encBit)
    else $error("encoded pulse does not follow seven low ticks");

  a_one_bit_dark : assert property (@(posedge core_clk)  // R02
    disable iff (!rst_b) encActive && encBit |-> !irPulseOut)
    else $error("one bit produced a pulse");

  a_cell_sixteen : assert property (@(posedge core_clk)  // R01
    disable iff (!rst_b) encWrap |=> encCnt == 4'h0)
    else $error("bit cell did not wrap after sixteen ticks");

  a_rx_cell_whole : assert property (@(posedge core_clk)  // R07
    disable iff (!rst_b) $rose(uartRxd) && $past(rxOn) && rxOn |->
    rxLowTicks[3:0] == 4'h0 && rxLowTicks != 8'h0)
    else $error("decoded low is not a whole number of cells");

  a_rx_gated : assert property (@(posedge core_clk)  // R08
    disable iff (!rst_b) !rxOn ##1 !rxOn |-> uartRxd)
    else $error("uart receive line moved while receive disabled");

  a_off_quiet : assert property (@(posedge core_clk)  // R17
    disable iff (!rst_b) !ctrl.endecEnable |=> !irPulseOut && !encActive)
    else $error("disabled endec still drives the output");

  a_ctrl_reset : assert property (@(posedge core_clk)  // R17
    !rst_b |=> ctrl == ise_pkg::CTRL_RESET)
    else $error("control register did not reset to zero");

  a_bresp_hold : assert property (@(posedge core_clk)
    disable iff (!rst_b) axiRsp.bvalid && !axiReq.bready |=>
    axiRsp.bvalid && $stable(axiRsp.bresp))
    else $error("write response dropped before acceptance");

  // read data stands until the master takes it
  a_rdata_hold : assert property (@(posedge core_clk)
    disable iff (!rst_b) axiRsp.rvalid && !axiReq.rready |=>
    axiRsp.rvalid && $stable(axiRsp.rdata) && $stable(axiRsp.rresp))
    else $error("read data changed before acceptance");

  // read answer comes one cycle after the address is taken
  a_read_latency : assert property (@(posedge core_clk)
    disable iff (!rst_b) arTake |=> axiRsp.rvalid && !axiRsp.arready)
    else $error("read answer late or address not refused");

  // write answer comes one cycle after the write fires
  a_write_latency : assert property (@(posedge core_clk)
    disable iff (!rst_b) doWrite |=> axiRsp.bvalid)
    else $error("write response not raised after the write");

  // a running cell never skips or stalls a tick before its end
  a_cell_step : assert property (@(posedge core_clk)  // R01
    disable iff (!rst_b) encActive && ctrl.endecEnable && baudTick &&
    encCnt != ise_pkg::CNT_LAST |=>
    encActive && encCnt == $past(encCnt) + 4'h1)
    else $error("bit cell ended early or lost a tick");

  // a falling uart line opens a zero cell when enabled
  a_tx_start : assert property (@(posedge core_clk)  // R09
    disable iff (!rst_b) encStart |=> encActive && !encBit &&
    encCnt == 4'h0)
    else $error("encoder did not start a zero cell");

  // with receive on the uart line follows the decoder
  a_rx_follow : assert property (@(posedge core_clk)  // R16
    disable iff (!rst_b) rxOn |=> uartRxd == $past(decRxd))
    else $error("uart receive line does not follow the decoder");

  // an idle decoder leaves the uart line high
  a_rx_idle_high : assert property (@(posedge core_clk)  // R18
    disable iff (!rst_b) !$past(rxBusy) |-> uartRxd)
    else $error("uart receive line low while decoder idle");

  c_zero_sent : cover property (@(posedge core_clk) disable iff (!rst_b)
    $rose(irPulseOut));
  c_zero_received : cover property (@(posedge core_clk)
    disable iff (!rst_b) rxOn && $fell(uartRxd));
  c_loopback_rx : cover property (@(posedge core_clk) disable iff (!rst_b)
    ctrl.loopback && rxOn && $fell(uartRxd));
  c_bad_address : cover property (@(posedge core_clk) disable iff (!rst_b)
    axiRsp.bvalid && axiRsp.bresp == ise_pkg::RESP_SLVERR);
  c_off_in_pulse : cover property (@(posedge core_clk)
    disable iff (!rst_b) irPulseOut && !ctrl.endecEnable);

endmodule

// >>> verification/ise_ir_transceiver.sv
// infrared transceiver model driving pulses into the endec receive pin
module ise_ir_transceiver (
  input  wire logic core_clk,
  input  wire logic baudTick,
  output logic      irLine
);
  timeunit 1ns;
  timeprecision 1ps;

  // receive pin idles high between cells
  initial irLine = 1'b1;

  // one cell of sixteen ticks: a zero is a three tick low pulse
  task automatic send(input logic b);
    for (int k = 1; k <= 16; k++) begin
      @(posedge core_clk iff baudTick === 1'b1);
      irLine <= !(b === 1'b0 && k >= 8 && k <= 10);
    end
  endtask
endmodule

// >>> verification/test_infrared_sir_endec.sv
// self-checking bench of the infrared serial endec
module test_infrared_sir_endec;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [1:0]  resp;
  } ise_row_type;

  logic                     core_clk = 1'b0;
  logic                     rst_b = 1'b0;
  logic                     baudTick = 1'b0;
  logic                     uartTxd = 1'b1;
  logic                     uartRxd;
  logic                     irPulseOut;
  wire logic                irPulseIn;
  ise_pkg::ise_axi_req_type req = '0;
  ise_pkg::ise_axi_rsp_type rsp;
  int                       numErrors = 0;
  int                       comparisons = 0;
  int                       cntOut, cntRx, firstOut, lastOut;
  logic [31:0]              rd;
  logic [1:0]               rs;
  ise_row_type              rows [4];

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  ise_endec u_ise_endec (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .axiReq     (req),
    .axiRsp     (rsp),
    .baudTick   (baudTick),
    .uartTxd    (uartTxd),
    .uartRxd    (uartRxd),
    .irPulseOut (irPulseOut),
    .irPulseIn  (irPulseIn)
  );

  ise_ir_transceiver u_ise_ir_transceiver (
    .core_clk (core_clk),
    .baudTick (baudTick),
    .irLine   (irPulseIn)
  );

  // verdict and end of run
  task automatic summarize;
    if (numErrors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      numErrors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // bus write, both channels offered together, held until taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      n++;
    end while (rsp.bvalid !== 1'b1 && n < 50);
    rs = rsp.bresp;
    req.bready <= 1'b0;
    if (rsp.bvalid !== 1'b1) begin
      numErrors++;
      summarize();
    end
  endtask

  // bus read, address held until taken, rready until rvalid
  task automatic axr(input logic [11:0] a);
    int n;
    @(posedge core_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      n++;
    end while (rsp.rvalid !== 1'b1 && n < 50);
    rd = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
    if (rsp.rvalid !== 1'b1) begin
      numErrors++;
      summarize();
    end
  endtask

  task automatic setCtrl(input logic [31:0] d);
    axw(ise_pkg::CTRL_ADDR, d);
    chk("bresp", 32'(rs), 32'(ise_pkg::RESP_OKAY));
  endtask

  // one baud tick every four core cycles, sample mid-cell
  task automatic tick;
    @(posedge core_clk);
    baudTick <= 1'b1;
    @(posedge core_clk);
    baudTick <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  // count output highs and receive lows over n ticks
  task automatic run(input int n);
    cntOut = 0;
    cntRx = 0;
    firstOut = 0;
    lastOut = 0;
    for (int k = 1; k <= n; k++) begin
      tick();
      if (irPulseOut === 1'b1) begin
        cntOut++;
        if (firstOut == 0) firstOut = k;
        lastOut = k;
      end
      if (uartRxd === 1'b0) cntRx++;
    end
  endtask

  // one low cycle of uart output: a zero cell then a one cell
  task automatic txZero;
    @(posedge core_clk);
    uartTxd <= 1'b0;
    @(posedge core_clk);
    uartTxd <= 1'b1;
  endtask

  initial begin
    rows[0] = '{ise_pkg::CTRL_ADDR, 32'hff, 32'h7, ise_pkg::RESP_OKAY};
    rows[1] = '{ise_pkg::STAT_ADDR, 32'h5, 32'h4, ise_pkg::RESP_OKAY};
    rows[2] = '{12'h004, 32'h1, 32'h0, ise_pkg::RESP_SLVERR};
    rows[3] = '{ise_pkg::CTRL_ADDR, 32'h0, 32'h0, ise_pkg::RESP_OKAY};
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk("uartRxd", 32'(uartRxd), 32'h1);
    chk("irPulseOut", 32'(irPulseOut), 32'h0);
    axr(ise_pkg::CTRL_ADDR);
    chk("ctrl", rd, 32'h0);
    // register rows: write, then read back
    foreach (rows[i]) begin
      axw(rows[i].addr, rows[i].wdata);
      chk("bresp", 32'(rs), 32'(rows[i].resp));
      axr(rows[i].addr);
      chk("rdata", rd, rows[i].rdata);
      chk("rresp", 32'(rs), 32'(rows[i].resp));
    end
    // transmit with receive path off
    setCtrl(32'h1);
    txZero();
    run(40);
    chk("txHigh", cntOut, 32'd3);
    chk("txFirst", firstOut, 32'd7);
    chk("txLast", lastOut, 32'd9);
    chk("rxQuiet", cntRx, 32'd0);
    // disable in mid pulse
    txZero();
    run(8);
    chk("txStart", firstOut, 32'd7);
    setCtrl(32'h0);
    run(20);
    chk("txOff", cntOut, 32'd0);
    // receive two zero cells back to back
    setCtrl(32'h3);
    fork
      begin
        u_ise_ir_transceiver.send(1'b0);
        u_ise_ir_transceiver.send(1'b0);
      end
    join_none
    run(50);
    chk("rxLow", cntRx, 32'd32);
    // receive enable cleared
    setCtrl(32'h1);
    fork
      u_ise_ir_transceiver.send(1'b0);
    join_none
    run(30);
    chk("rxIgnored", cntRx, 32'd0);
    // internal loopback
    setCtrl(32'h7);
    txZero();
    run(40);
    chk("loopRx", cntRx, 32'd16);
    chk("loopTx", cntOut, 32'd3);
    // reset in mid pulse clears control, output and receive line
    txZero();
    run(8);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk("rstRxd", 32'(uartRxd), 32'h1);
    chk("rstOut", 32'(irPulseOut), 32'h0);
    axr(ise_pkg::CTRL_ADDR);
    chk("rstCtrl", rd, 32'h0);
    summarize();
  end
endmodule
